// >>> src/bli_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Bit set forces chosen bit of addressed file register to one, flags untouched.
// - Literal AND puts W AND literal into W, changes only zero flag.
// - Bit test skip: bit one discards next instruction as a no-op; two cycles.
// - Register AND writes W AND file to W when dest 0, file when 1.
module bli_exec
  import bli_pkg::*;
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  input  wire bli_instr_s             instr_in,
  input  wire logic      [DATA_W-1:0] file_rd_data_in,
  output logic           [ADDR_W-1:0] file_rd_addr_out,
  output bli_wr_s                     file_wr_out,
  output logic           [DATA_W-1:0] w_out,
  output logic                        zero_out,
  output logic                        zero_upd_out,
  output logic                        skipped_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bli_state_e        state_reg,   state_next;
  logic [DATA_W-1:0] w_reg,       w_next;
  logic              zero_reg,    zero_next;
  logic              zupd_reg,    zupd_next;
  logic              skip_reg,    skip_next;
  bli_wr_s           wr_reg,      wr_next;
  logic [DATA_W-1:0] and_res;
  logic              and_zero;
  logic [DATA_W-1:0] set_res;
  logic              tst_bit;
  logic [DATA_W-1:0] alu_b;

  // File read is combinational: the register file answers in the same cycle
  assign file_rd_addr_out = instr_in.addr;

  // Literal AND takes its operand from the instruction, all others from the file
  always_comb begin
    alu_b = (instr_in.op == BLI_OP_ANDL) ? instr_in.literal : file_rd_data_in;
  end

  bli_alu u_alu (
    .a_in       (w_reg),
    .b_in       (alu_b),
    .bit_sel_in (instr_in.bit_sel),
    .and_out    (and_res),
    .zero_out   (and_zero),
    .set_out    (set_res),
    .bit_out    (tst_bit)
  );

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    w_next     = w_reg;
    zero_next  = zero_reg;
    zupd_next  = 1'b0;
    skip_next  = 1'b0;
    wr_next    = '0;
    case (state_reg)
      BLI_ST_SKIP: begin
        // Fetched instruction is dropped; this cycle is the no-op
        skip_next  = 1'b1;
        state_next = BLI_ST_RUN;
      end
      default: begin
        state_next = BLI_ST_RUN;
        if (instr_in.valid) begin
          case (instr_in.op)
            BLI_OP_SETB: begin
              wr_next = '{valid: 1'b1, addr: instr_in.addr, data: set_res};
            end
            BLI_OP_ANDL: begin
              w_next    = and_res;
              zero_next = and_zero;
              zupd_next = 1'b1;
            end
            BLI_OP_TSTS: begin
              if (tst_bit) begin
                state_next = BLI_ST_SKIP;
              end
            end
            BLI_OP_ANDF: begin
              if (instr_in.dest == DEST_FILE) begin
                wr_next = '{valid: 1'b1, addr: instr_in.addr, data: and_res};
              end else begin
                w_next = and_res;
              end
              zero_next = and_zero;
              zupd_next = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  // Reset parks the core in RUN so the first fetch is never dropped
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= BLI_ST_RUN;
      w_reg     <= W_RST;
      zero_reg  <= ZERO_RST;
      zupd_reg  <= 1'b0;
      skip_reg  <= 1'b0;
      wr_reg    <= '0;
    end else begin
      state_reg <= state_next;
      w_reg     <= w_next;
      zero_reg  <= zero_next;
      zupd_reg  <= zupd_next;
      skip_reg  <= skip_next;
      wr_reg    <= wr_next;
    end
  end

  // Write pulse is registered; the file lands it one cycle after issue
  assign file_wr_out  = wr_reg;
  assign w_out        = w_reg;
  assign zero_out     = zero_reg;
  assign zero_upd_out = zupd_reg;
  assign skipped_out  = skip_reg;

  // ----------------------------------------------------------------
  // Decode for checks
  // ----------------------------------------------------------------
  // Skip slot never counts as taken, so no check fires on a dropped op
  function automatic logic op_taken(input bli_state_e st, input bli_instr_s ins, input bli_op_e op);
    return (st == BLI_ST_RUN) && ins.valid && (ins.op == op);
  endfunction : op_taken

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Taken ops are sampled in RUN only; the skip slot is checked on its own
  set_bit_write_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_reg == BLI_ST_RUN && instr_in.valid && instr_in.op == BLI_OP_SETB)
    |=> (wr_reg.valid && wr_reg.data[$past(instr_in.bit_sel)] && $stable(zero_reg)))
    else $error("bit set did not write a one");

  and_lit_w_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_reg == BLI_ST_RUN && instr_in.valid && instr_in.op == BLI_OP_ANDL)
    |=> (w_reg == ($past(w_reg) & $past(instr_in.literal)) && !wr_reg.valid))
    else $error("literal and gave wrong w");

  skip_two_cyc_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_reg == BLI_ST_RUN && instr_in.valid && instr_in.op == BLI_OP_TSTS && tst_bit)
    |=> (state_reg == BLI_ST_SKIP) ##1 (skipped_out && !wr_reg.valid && $stable(w_reg) && $stable(zero_reg)))
    else $error("set bit did not skip next instruction");

  no_skip_clear_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_reg == BLI_ST_RUN && instr_in.valid && instr_in.op == BLI_OP_TSTS && !tst_bit)
    |=> (state_reg == BLI_ST_RUN && $stable(zero_reg)))
    else $error("clear bit caused a skip");

  and_reg_dest_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_reg == BLI_ST_RUN && instr_in.valid && instr_in.op == BLI_OP_ANDF && instr_in.dest == DEST_FILE)
    |=> (wr_reg.valid && wr_reg.data == ($past(w_reg) & $past(file_rd_data_in)) && $stable(w_reg)))
    else $error("register and missed file write");

  zero_flag_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    zupd_reg |-> (zero_reg == ((wr_reg.valid ? wr_reg.data : w_reg) == 8'h00)))
    else $error("zero flag does not match result");

  set_bit_keep_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_taken(state_reg, instr_in, BLI_OP_SETB)
    |=> (wr_reg.addr == $past(instr_in.addr)
         && wr_reg.data == ($past(file_rd_data_in) | (8'h01 << $past(instr_in.bit_sel)))
         && $stable(w_reg) && !zupd_reg))
    else $error("bit set disturbed other bits");

  and_lit_flag_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_taken(state_reg, instr_in, BLI_OP_ANDL)
    |=> (zupd_reg && zero_reg == (($past(w_reg) & $past(instr_in.literal)) == 8'h00)))
    else $error("literal and left zero flag wrong");

  and_reg_w_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (op_taken(state_reg, instr_in, BLI_OP_ANDF) && instr_in.dest == DEST_W)
    |=> (w_reg == ($past(w_reg) & $past(file_rd_data_in)) && !wr_reg.valid && zupd_reg))
    else $error("register and missed w update");

  and_reg_flag_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_taken(state_reg, instr_in, BLI_OP_ANDF)
    |=> (zero_reg == (($past(w_reg) & $past(file_rd_data_in)) == 8'h00)))
    else $error("register and left zero flag wrong");

  test_quiet_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_taken(state_reg, instr_in, BLI_OP_TSTS)
    |=> (!wr_reg.valid && !zupd_reg && $stable(w_reg)))
    else $error("bit test changed state");

  // ----------------------------------------------------------------
  // Skip slot and holding checks
  // ----------------------------------------------------------------
  // Dropped op must leave no trace, or a skipped write would still land
  skip_drop_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_reg == BLI_ST_SKIP)
    |=> (state_reg == BLI_ST_RUN && skip_reg && !wr_reg.valid && !zupd_reg))
    else $error("skip slot did not drop its op");

  skip_source_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    skip_reg |-> ($past(state_reg) == BLI_ST_SKIP))
    else $error("skip pulse without a skip slot");

  // Only an AND may move W or the flag
  zero_hold_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !zupd_reg |-> $stable(zero_reg))
    else $error("zero flag moved without an and");

  w_hold_a : assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !zupd_reg |-> $stable(w_reg))
    else $error("w moved without an and");

endmodule : bli_exec

// >>> src/bli_pkg.sv
package bli_pkg;

  // ----------------------------------------------------------------
  // Operand widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // All ones, so the AND paths meet a live W straight after reset
  localparam logic [7:0] W_RST    = 8'hff;
  localparam logic       ZERO_RST = 1'b0;

  // ----------------------------------------------------------------
  // Operation and destination codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BLI_OP_NONE = 4'h0,
    BLI_OP_SETB = 4'h1,
    BLI_OP_ANDL = 4'h2,
    BLI_OP_TSTS = 4'h3,
    BLI_OP_ANDF = 4'h4
  } bli_op_e;

  localparam logic DEST_W    = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    BLI_ST_RUN  = 2'b01,
    BLI_ST_SKIP = 2'b10
  } bli_state_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    bli_op_e           op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0]  bit_sel;
    logic              dest;
    logic [DATA_W-1:0] literal;
  } bli_instr_s;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bli_wr_s;

endpackage : bli_pkg

// >>> src/bli_alu.sv
`timescale 1ns/1ps
module bli_alu
  import bli_pkg::*;
(
  input  wire logic [DATA_W-1:0] a_in,
  input  wire logic [DATA_W-1:0] b_in,
  input  wire logic [BIT_W-1:0]  bit_sel_in,
  output logic      [DATA_W-1:0] and_out,
  output logic                   zero_out,
  output logic      [DATA_W-1:0] set_out,
  output logic                   bit_out
);

  always_comb begin
    and_out  = a_in & b_in;
    zero_out = (and_out == '0);
    set_out  = b_in | (8'h01 << bit_sel_in);
    bit_out  = b_in[bit_sel_in];
  end

endmodule : bli_alu

// >>> verification/bli_exec_tb_top.sv
`timescale 1ns/1ps
module bli_exec_tb_top
  import bli_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, file model and expectations
  // ----------------------------------------------------------------
  logic              clk_sys_in      = 1'b0;
  logic              nrst_in         = 1'b0;
  bli_instr_s        instr_in        = '0;
  logic [DATA_W-1:0] file_rd_data_in;
  logic [ADDR_W-1:0] file_rd_addr_out;
  bli_wr_s           file_wr_out;
  logic [DATA_W-1:0] w_out;
  logic              zero_out;
  logic              zero_upd_out;
  logic              skipped_out;
  logic [7:0]        mem [128];
  logic [7:0]        em [128];
  logic [7:0]        lf = 8'h16;
  logic [7:0]        ew = W_RST;
  logic [7:0]        e_wd = 8'h00;
  logic [6:0]        e_wa = 7'h00;
  logic              ez = ZERO_RST;
  logic              e_wv = 1'b0, e_zu = 1'b0, e_sk = 1'b0, sk = 1'b0;
  int                err_total = 0, checks_done = 0, cyc = 0;

  bli_exec dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .instr_in(instr_in),
    .file_rd_data_in(file_rd_data_in), .file_rd_addr_out(file_rd_addr_out), .file_wr_out(file_wr_out),
    .w_out(w_out), .zero_out(zero_out), .zero_upd_out(zero_upd_out), .skipped_out(skipped_out));

  initial forever #2.5 clk_sys_in = ~clk_sys_in;

  // Forward the pending write: write-back lands one cycle late
  assign file_rd_data_in = (file_wr_out.valid && file_wr_out.addr == file_rd_addr_out) ?
                           file_wr_out.data : mem[file_rd_addr_out];

  always @(posedge clk_sys_in) begin
    if (file_wr_out.valid === 1'b1) mem[file_wr_out.addr] <= file_wr_out.data;
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      give_verdict();
    end
  end

  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nxt

  function automatic logic z_of(input logic [7:0] r);
    return r == 8'h00;
  endfunction : z_of

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : chk

  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // Checks the previous cycle's results, then presents the next instruction
  task automatic issue(input bli_op_e op, input logic [6:0] a, input logic [2:0] b, input logic d,
                       input logic [7:0] k);
    logic [7:0] r;
    @(negedge clk_sys_in);
    chk("wr_valid", 8'(file_wr_out.valid), 8'(e_wv));
    if (e_wv) begin
      chk("wr_addr", 8'(file_wr_out.addr), 8'(e_wa));
      chk("wr_data", file_wr_out.data, e_wd);
    end
    chk("w", w_out, ew);
    chk("zero", 8'(zero_out), 8'(ez));
    chk("zero_upd", 8'(zero_upd_out), 8'(e_zu));
    chk("skipped", 8'(skipped_out), 8'(e_sk));
    chk("rd_addr", 8'(file_rd_addr_out), 8'(e_wa));
    instr_in = '{1'b1, op, a, b, d, k};
    r = ew & em[a];
    e_wv = 1'b0;
    e_zu = 1'b0;
    e_sk = sk;
    e_wa = a;
    if (sk) sk = 1'b0;
    else case (op)
      BLI_OP_SETB: begin em[a][b] = 1'b1; e_wv = 1'b1; e_wd = em[a]; end
      BLI_OP_ANDL: begin ew = ew & k; ez = z_of(ew); e_zu = 1'b1; end
      BLI_OP_TSTS: sk = em[a][b];
      BLI_OP_ANDF: begin
        ez = z_of(r);
        e_zu = 1'b1;
        if (d) begin em[a] = r; e_wv = 1'b1; e_wd = r; end
        else ew = r;
      end
      default: ;
    endcase
  endtask : issue

  // ----------------------------------------------------------------
  // Sequence: corners first, then random traffic
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) begin
      lf = nxt(lf);
      mem[i] = lf;
      em[i] = lf;
    end
    repeat (16) @(posedge clk_sys_in);
    @(negedge clk_sys_in) nrst_in = 1'b1;
    issue(BLI_OP_SETB, 7'h7f, 3'h7, 1'b0, 8'h00);
    issue(BLI_OP_SETB, 7'h7f, 3'h0, 1'b0, 8'h00);
    issue(BLI_OP_TSTS, 7'h7f, 3'h7, 1'b0, 8'h00);
    issue(BLI_OP_SETB, 7'h00, 3'h1, 1'b0, 8'h00);
    issue(BLI_OP_ANDF, 7'h10, 3'h0, 1'b1, 8'h00);
    issue(BLI_OP_TSTS, 7'h10, 3'h3, 1'b0, 8'h00);
    issue(BLI_OP_SETB, 7'h10, 3'h3, 1'b0, 8'h00);
    issue(BLI_OP_ANDL, 7'h00, 3'h0, 1'b0, 8'hff);
    issue(BLI_OP_ANDF, 7'h7f, 3'h0, 1'b0, 8'h00);
    issue(BLI_OP_ANDL, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(BLI_OP_ANDF, 7'h22, 3'h0, 1'b1, 8'h00);
    // W only narrows under AND, so periodic resets bring it back to all ones
    for (int i = 0; i < 400; i++) begin
      lf = nxt(lf);
      r_issue(bli_op_e'(4'(lf % 8'h05)));
      if (i % 25 == 24) pulse_reset();
    end
    issue(BLI_OP_NONE, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(BLI_OP_NONE, 7'h00, 3'h0, 1'b0, 8'h00);
    give_verdict();
  end

  task automatic r_issue(input bli_op_e op);
    logic [7:0] x, y;
    x = nxt(lf);
    y = nxt(x);
    lf = y;
    issue(op, x[6:0], y[2:0], x[7], y);
  endtask : r_issue

  // Mid-run reset; the idle op first lets any pending write land in the file
  task automatic pulse_reset();
    issue(BLI_OP_NONE, 7'h00, 3'h0, 1'b0, 8'h00);
    @(negedge clk_sys_in);
    nrst_in = 1'b0;
    instr_in = '0;
    ew = W_RST;
    ez = ZERO_RST;
    e_wv = 1'b0;
    e_zu = 1'b0;
    e_sk = 1'b0;
    sk = 1'b0;
    e_wa = 7'h00;
    repeat (2) @(negedge clk_sys_in);
    nrst_in = 1'b1;
  endtask : pulse_reset
endmodule : bli_exec_tb_top
